// >>> hw/bbat_pkg.sv
// shared constants and types for the byte bus master agent
package bbat_pkg;

    localparam int BBAT_ADDR_W = 16;
    localparam int BBAT_DATA_W = 8;
    localparam int BBAT_SIZE_W = 2;
    localparam int BBAT_FIFO_DEPTH = 32;
    localparam int BBAT_CNT_W = 4;
    localparam int BBAT_LVL_W = 6;

    // burst size encodings
    localparam logic [1:0] BBAT_SZ_1B = 2'h0;
    localparam logic [1:0] BBAT_SZ_2B = 2'h1;
    localparam logic [1:0] BBAT_SZ_4B = 2'h2;
    localparam logic [1:0] BBAT_SZ_8B = 2'h3;

    // released / reset values of driven bus fields, and beat count constants
    localparam logic [15:0] BBAT_ADDR_RST = 16'h0000;
    localparam logic [7:0] BBAT_DATA_RST = 8'h00;
    localparam logic [3:0] BBAT_CNT_RST = 4'h0;
    localparam logic [3:0] BBAT_BEAT_ONE = 4'h1;
    localparam logic [3:0] BBAT_BEAT_TWO = 4'h2;

    typedef enum logic [2:0] {
        BBAT_ST_IDLE = 3'b000,
        BBAT_ST_PREP = 3'b001,
        BBAT_ST_REQ = 3'b010,
        BBAT_ST_ADDR = 3'b011,
        BBAT_ST_DATA = 3'b100
    } bbat_state_t;

    typedef struct packed {
        logic write;
        logic [BBAT_SIZE_W-1:0] size;
        logic [BBAT_ADDR_W-1:0] addr;
    } bbat_cmd_t;

endpackage

// >>> hw/bbat_fifo.sv
// write data buffer, parameterised width and depth, valid/ready both sides
`timescale 1ns/10ps
module bbat_fifo
    import bbat_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 32
)
(
    input wire logic sys_clk, // system clock
    input wire logic rstn, // sync reset, active low
    input wire logic in_valid, // producer has a word
    input wire logic [W-1:0] in_data, // producer word
    output logic in_ready, // room for a word
    output logic out_valid, // head word present
    input wire logic out_ready, // consumer takes head
    output logic [W-1:0] out_data, // head word
    output logic [$clog2(D+1)-1:0] level // words held
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] count;
        logic in_ready;
    } bbat_fifo_st_t;

    bbat_fifo_st_t s_r;
    bbat_fifo_st_t s_nxt;
    logic push;
    logic pop;

    always_comb
    begin
        s_nxt = s_r;
        push = in_valid && s_r.in_ready;
        pop = out_ready && (s_r.count != '0);
        if (push)
        begin
            s_nxt.mem[s_r.wptr] = in_data;
            s_nxt.wptr = PW'(s_r.wptr + 1'b1);
        end
        if (pop)
        begin
            s_nxt.rptr = PW'(s_r.rptr + 1'b1);
        end
        s_nxt.count = CW'(s_r.count + CW'(push) - CW'(pop));
        s_nxt.in_ready = (s_nxt.count < CW'(D));
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign in_ready = s_r.in_ready;
    assign out_valid = (s_r.count != '0);
    assign out_data = s_r.mem[s_r.rptr];
    assign level = s_r.count;

endmodule // bbat_fifo

// >>> hw/bbat_beats.sv
// count of bytes still owed in the current burst
`timescale 1ns/10ps
module bbat_beats
    import bbat_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rstn, // sync reset, active low
    input wire logic load, // start a burst
    input wire logic [BBAT_CNT_W-1:0] len, // burst length in bytes
    input wire logic dec, // one byte finished
    output logic [BBAT_CNT_W-1:0] cnt // bytes left incl. current
);
    typedef struct packed {
        logic [BBAT_CNT_W-1:0] cnt;
    } bbat_beats_st_t;

    bbat_beats_st_t s_r;
    bbat_beats_st_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (load)
        begin
            s_nxt.cnt = len;
        end
        else if (dec && (s_r.cnt != BBAT_CNT_RST))
        begin
            s_nxt.cnt = BBAT_CNT_W'(s_r.cnt - BBAT_BEAT_ONE);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cnt = s_r.cnt;

endmodule // bbat_beats

// >>> hw/bbat_master.sv
// bus master agent: requests the bus, drives address and data phases
`timescale 1ns/10ps
module bbat_master
    import bbat_pkg::*;
(
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic rstn, // sync reset, active low
    input wire logic cmd_valid, // user offers a transfer
    input wire bbat_cmd_t cmd, // address, size, direction
    output logic cmd_ready, // ready to accept a transfer (goes high one cycle after idle is entered)
    input wire logic wr_valid, // user write byte valid
    input wire logic [BBAT_DATA_W-1:0] wr_data, // user write byte
    output logic wr_ready, // write buffer has room
    output logic rd_valid, // read byte pulse
    output logic [BBAT_DATA_W-1:0] rd_data, // read byte
    output logic done, // transfer finished pulse
    output logic fail, // last transfer ended by error
    output logic bus_req, // request line to arbiter
    input wire logic bus_gnt, // grant line from arbiter
    output logic [BBAT_ADDR_W-1:0] bus_addr, // first byte address
    output logic [BBAT_SIZE_W-1:0] bus_size, // burst size code
    output logic bus_read, // read transfer
    output logic bus_write, // write transfer
    output logic ctl_oe, // drive enable for addr/size/read/write
    output logic bus_bip, // burst in progress
    output logic bip_oe, // drive enable for bus_bip
    input wire logic [BBAT_DATA_W-1:0] data_in, // data pins sampled
    output logic [BBAT_DATA_W-1:0] data_out, // data pins driven
    output logic data_oe, // drive enable for data pins
    input wire logic bus_wait, // slave stretches the cycle
    input wire logic bus_error // slave reports a failed byte
);

    typedef struct packed {
        bbat_state_t state;
        bbat_cmd_t cmd;
        logic cmd_ready;
        logic req;
        logic ctl_oe;
        logic [BBAT_ADDR_W-1:0] addr;
        logic [BBAT_SIZE_W-1:0] size;
        logic rd;
        logic wr;
        logic bip;
        logic bip_oe;
        logic [BBAT_DATA_W-1:0] dout;
        logic dout_oe;
        logic rd_valid;
        logic [BBAT_DATA_W-1:0] rd_data;
        logic done;
        logic fail;
    } bbat_mst_st_t;

    bbat_mst_st_t s_r;
    bbat_mst_st_t s_nxt;
    logic pop;
    logic load;
    logic dec;
    logic fifo_valid;
    logic [BBAT_DATA_W-1:0] fifo_data;
    logic [BBAT_LVL_W-1:0] fifo_level;
    logic [BBAT_CNT_W-1:0] beat_cnt;

    // bytes in a burst from its size code
    function automatic logic [BBAT_CNT_W-1:0] burst_len(input logic [BBAT_SIZE_W-1:0] sz);
        logic [BBAT_CNT_W-1:0] n;
        case (sz)
            BBAT_SZ_1B: n = 4'h1;
            BBAT_SZ_2B: n = 4'h2;
            BBAT_SZ_4B: n = 4'h4;
            BBAT_SZ_8B: n = 4'h8;
            default: n = 4'h1;
        endcase
        return n;
    endfunction

    // last cycle of a data phase
    function automatic logic phase_end(input logic err, input logic wt, input logic bip);
        return err || (!bip && !wt);
    endfunction

    bbat_fifo #(
        .W(BBAT_DATA_W),
        .D(BBAT_FIFO_DEPTH)
    ) u_wbuf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(wr_valid),
        .in_data(wr_data),
        .in_ready(wr_ready),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data),
        .level(fifo_level)
    );

    bbat_beats u_beats (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(load),
        .len(burst_len(s_r.cmd.size)),
        .dec(dec),
        .cnt(beat_cnt)
    );

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.rd_valid = 1'b0;
        pop = 1'b0;
        load = 1'b0;
        dec = 1'b0;
        case (s_r.state)
            BBAT_ST_IDLE:
            begin
                s_nxt.cmd_ready = 1'b1;
                if (cmd_valid && s_r.cmd_ready)
                begin
                    s_nxt.cmd = cmd;
                    s_nxt.cmd_ready = 1'b0;
                    s_nxt.fail = 1'b0;
                    s_nxt.state = BBAT_ST_PREP;
                end
            end
            BBAT_ST_PREP:
            begin
                // a write waits until the whole burst is buffered
                if (!s_r.cmd.write ||
                    (fifo_level >= {2'h0, burst_len(s_r.cmd.size)}))
                begin
                    s_nxt.req = 1'b1;
                    s_nxt.state = BBAT_ST_REQ;
                end
            end
            BBAT_ST_REQ:
            begin
                if (bus_gnt)
                begin
                    s_nxt.req = 1'b0;
                    s_nxt.ctl_oe = 1'b1;
                    s_nxt.addr = s_r.cmd.addr;
                    s_nxt.size = s_r.cmd.size;
                    s_nxt.rd = !s_r.cmd.write;
                    s_nxt.wr = s_r.cmd.write;
                    load = 1'b1;
                    s_nxt.state = BBAT_ST_ADDR;
                end
            end
            BBAT_ST_ADDR:
            begin
                s_nxt.ctl_oe = 1'b0;
                s_nxt.addr = BBAT_ADDR_RST;
                s_nxt.size = BBAT_SZ_1B;
                s_nxt.rd = 1'b0;
                s_nxt.wr = 1'b0;
                s_nxt.bip_oe = 1'b1;
                s_nxt.bip = (s_r.cmd.size != BBAT_SZ_1B);
                if (s_r.cmd.write)
                begin
                    pop = fifo_valid;
                    s_nxt.dout = fifo_data;
                    s_nxt.dout_oe = 1'b1;
                end
                s_nxt.state = BBAT_ST_DATA;
            end
            BBAT_ST_DATA:
            begin
                if (!bus_wait && !bus_error && !s_r.cmd.write)
                begin
                    s_nxt.rd_valid = 1'b1;
                    s_nxt.rd_data = data_in;
                end
                if (phase_end(bus_error, bus_wait, s_r.bip))
                begin
                    s_nxt.fail = bus_error;
                    s_nxt.done = 1'b1;
                    s_nxt.bip = 1'b0;
                    s_nxt.bip_oe = 1'b0;
                    s_nxt.dout_oe = 1'b0;
                    s_nxt.dout = BBAT_DATA_RST;
                    s_nxt.state = BBAT_ST_IDLE;
                end
                else if (!bus_wait)
                begin
                    dec = 1'b1;
                    s_nxt.bip = (beat_cnt > BBAT_BEAT_TWO);
                    if (s_r.cmd.write)
                    begin
                        pop = fifo_valid;
                        s_nxt.dout = fifo_data;
                    end
                end
            end
            default:
            begin
                s_nxt.state = BBAT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = s_r.cmd_ready;
    assign rd_valid = s_r.rd_valid;
    assign rd_data = s_r.rd_data;
    assign done = s_r.done;
    assign fail = s_r.fail;
    assign bus_req = s_r.req;
    assign bus_addr = s_r.addr;
    assign bus_size = s_r.size;
    assign bus_read = s_r.rd;
    assign bus_write = s_r.wr;
    assign ctl_oe = s_r.ctl_oe;
    assign bus_bip = s_r.bip;
    assign bip_oe = s_r.bip_oe;
    assign data_out = s_r.dout;
    assign data_oe = s_r.dout_oe;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_granted;
        (s_r.state == BBAT_ST_REQ) && bus_gnt;
    endsequence

    sequence s_addr_then_data;
        ctl_oe && !bip_oe ##1 !ctl_oe && bip_oe;
    endsequence

    property p_phase_order;
        s_granted |=> s_addr_then_data;
    endproperty
    a_phase_order: assert property (p_phase_order)
        else $error("address phase not one cycle before data phase");

    property p_addr_valid;
        s_granted |=> !bus_req && (bus_read != bus_write) && bus_addr == s_r.cmd.addr;
    endproperty
    a_addr_valid: assert property (p_addr_valid)
        else $error("address phase content wrong after grant");

    property p_release_ctl;
        bip_oe |-> !ctl_oe && bus_addr == BBAT_ADDR_RST && !bus_read && !bus_write;
    endproperty
    a_release_ctl: assert property (p_release_ctl)
        else $error("address signals driven in data phase");

    property p_wr_only;
        data_oe |-> s_r.cmd.write && bip_oe;
    endproperty
    a_wr_only: assert property (p_wr_only)
        else $error("data driven outside a write data phase");

    property p_hold_on_wait;
        (s_r.state == BBAT_ST_DATA && bus_wait && !bus_error) |=>
            $stable(data_out) && $stable(bus_bip) && bip_oe;
    endproperty
    a_hold_on_wait: assert property (p_hold_on_wait)
        else $error("byte or bip changed during a wait state");

    property p_req_ready;
        (bus_req && s_r.cmd.write) |-> fifo_level >= {2'h0, burst_len(s_r.cmd.size)};
    endproperty
    a_req_ready: assert property (p_req_ready)
        else $error("write requested without full burst buffered");

    property p_single_no_bip;
        (s_r.state == BBAT_ST_ADDR && s_r.cmd.size == BBAT_SZ_1B) |=> bip_oe && !bus_bip;
    endproperty
    a_single_no_bip: assert property (p_single_no_bip)
        else $error("single byte burst left bip high");

    property p_release_end;
        (s_r.state == BBAT_ST_DATA && phase_end(bus_error, bus_wait, bus_bip)) |=>
            !bip_oe && !data_oe && !ctl_oe && done ##1 !done;
    endproperty
    a_release_end: assert property (p_release_end)
        else $error("bus not released after last data cycle");

    property p_error_ends;
        (s_r.state == BBAT_ST_DATA && bus_error && bus_bip) |=>
            fail && s_r.state == BBAT_ST_IDLE && !rd_valid;
    endproperty
    a_error_ends: assert property (p_error_ends)
        else $error("error did not end the data phase");

    property p_read_capture;
        (s_r.state == BBAT_ST_DATA && !s_r.cmd.write && !bus_wait && !bus_error) |=>
            rd_valid && rd_data == $past(data_in);
    endproperty
    a_read_capture: assert property (p_read_capture)
        else $error("read byte not captured on wait low");

    property p_no_capture_wait;
        (s_r.state == BBAT_ST_DATA && bus_wait) |=> !rd_valid;
    endproperty
    a_no_capture_wait: assert property (p_no_capture_wait)
        else $error("read byte captured during wait");

endmodule // bbat_master

// >>> dv/bbat_dev_model.sv
// device model: central arbiter plus one byte-wide slave with wait and error control
`timescale 1ns/10ps
module bbat_dev_model
    import bbat_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rstn, // sync reset, active low
    input wire logic bus_req, // master request
    output logic bus_gnt, // grant, falling edge
    input wire logic [15:0] bus_addr, // master address
    input wire logic [1:0] bus_size, // size code
    input wire logic bus_read, // read
    input wire logic bus_write, // write
    input wire logic ctl_oe, // control enable
    input wire logic bus_bip, // burst in progress
    input wire logic bip_oe, // bip enable
    input wire logic [7:0] data_out, // master data
    input wire logic data_oe, // master data enable
    output logic [7:0] data_in, // resolved data wire
    output logic bus_wait, // wait
    output logic bus_error, // error
    output logic start, // arbitration phase
    input wire logic [3:0] nwait, // waits per byte
    input wire logic [3:0] ebeat, // failing byte index
    output int viol // master faults seen
);
    typedef enum logic [1:0] {PH_NOP, PH_ARB, PH_ADR, PH_DAT} bbat_ph_t;
    bbat_ph_t ph;
    logic [7:0] mem [0:255];
    logic [15:0] a_r;
    logic [3:0] len_r, beat, wc;
    logic w_r, wprev;
    logic [7:0] last, dprev, ba;
    assign ba = a_r[7:0] + {4'h0, beat};
    assign start = (ph == PH_ARB);
    assign bus_wait = (ph == PH_DAT) && (wc < nwait);
    assign bus_error = (ph == PH_DAT) && !bus_wait && (beat == ebeat);
    // released wire shows the inverse of its last level
    assign data_in = (ph == PH_DAT && !w_r && !bus_wait) ? mem[ba] : data_oe ? data_out : ~last;
    always_ff @(negedge sys_clk)
    begin
        bus_gnt <= start && bus_req;
    end
    always_ff @(posedge sys_clk)
    begin
        last <= data_in;
        wprev <= bus_wait;
        dprev <= data_out;
        if (!rstn)
        begin
            ph <= PH_NOP;
            viol <= 0;
        end
        else
        begin
            if (ph != PH_ADR && ph != PH_DAT && (ctl_oe || bip_oe || data_oe))
                viol <= viol + 1;
            case (ph)
            PH_NOP: ph <= PH_ARB;
            PH_ARB: ph <= bus_gnt ? PH_ADR : PH_NOP;
            PH_ADR:
            begin
                if (!ctl_oe || !(bus_read ^ bus_write) || bus_req)
                    viol <= viol + 1;
                a_r <= bus_addr;
                len_r <= 4'h1 << bus_size;
                w_r <= bus_write;
                beat <= 4'h0;
                wc <= 4'h0;
                ph <= PH_DAT;
            end
            default:
            begin
                if (ctl_oe || !bip_oe || data_oe != w_r
                    || (!bus_wait && bus_bip != (beat != len_r - 4'h1))
                    || (w_r && wprev && data_out != dprev))
                    viol <= viol + 1;
                wc <= bus_wait ? wc + 4'h1 : 4'h0;
                if (!bus_wait)
                begin
                    if (w_r && !bus_error)
                        mem[ba] <= data_out;
                    beat <= beat + 4'h1;
                end
                if (bus_error || (!bus_bip && !bus_wait))
                    ph <= PH_ARB;
            end
            endcase
        end
    end
endmodule // bbat_dev_model

// >>> dv/tb_byte_bus_arbiter_transfer.sv
// self-checking bench for the byte bus master agent
`timescale 1ns/10ps
module tb_byte_bus_arbiter_transfer
    import bbat_pkg::*;
;
    logic sys_clk, rstn, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, fail;
    logic bus_req, bus_gnt, bus_read, bus_write, ctl_oe, bus_bip, bip_oe, data_oe;
    logic bus_wait, bus_error, start;
    bbat_cmd_t cmd;
    logic [7:0] wr_data, rd_data, data_in, data_out, pat;
    logic [15:0] bus_addr;
    logic [1:0] bus_size;
    logic [3:0] nwait, ebeat;
    int viol, fails, n_compared;
    logic [7:0] exp_mem [0:255];
    logic [7:0] rdq [$];
    logic [7:0] tq [$];

    bbat_master bbat_master_inst (.sys_clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .wr_valid,
        .wr_data, .wr_ready, .rd_valid, .rd_data, .done, .fail, .bus_req, .bus_gnt, .bus_addr,
        .bus_size, .bus_read, .bus_write, .ctl_oe, .bus_bip, .bip_oe, .data_in, .data_out,
        .data_oe, .bus_wait, .bus_error);
    bbat_dev_model bbat_dev_model_inst (.sys_clk, .rstn, .bus_req, .bus_gnt, .bus_addr,
        .bus_size, .bus_read, .bus_write, .ctl_oe, .bus_bip, .bip_oe, .data_out, .data_oe,
        .data_in, .bus_wait, .bus_error, .start, .nwait, .ebeat, .viol);

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        if (rd_valid === 1'b1)
            rdq.push_back(rd_data);
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task complete_run;
    begin
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task push(input int n);
        int k;
    begin
        for (k = 0; k < n; k++)
        begin
            @(posedge sys_clk);
            wr_valid <= 1'b1;
            wr_data <= pat;
            tq.push_back(pat);
            pat = pat + 8'h1;
        end
        @(posedge sys_clk);
        wr_valid <= 1'b0;
    end
    endtask
    task wait_done;
        int i;
    begin
        for (i = 0; i < 300; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (done === 1'b1)
                return;
        end
        fails++;
        complete_run();
    end
    endtask
    // one transfer; eb at or above the burst length means no error
    task xfer(input logic w, input logic [1:0] sz, input logic [7:0] a, input logic [3:0] nw,
        input logic [3:0] eb);
        int len, ok, k;
        logic [7:0] b;
    begin
        len = 1 << sz;
        ok = (eb < len) ? int'(eb) : len;
        if (w && tq.size() < len)
            push(len);
        rdq.delete();
        nwait <= nw;
        ebeat <= eb;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd <= '{write: w, size: sz, addr: {8'h00, a}};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        wait_done();
        @(posedge sys_clk);
        #1;
        // bytes past a failed one stay buffered for the next write
        for (k = 0; k < len && k <= int'(eb) && w; k++)
        begin
            b = tq.pop_front();
            if (k < ok)
                exp_mem[8'(a + k)] = b;
        end
        chk(16'(rdq.size()), 16'(w ? 0 : ok));
        for (k = 0; k < len && w; k++)
            chk(16'(bbat_dev_model_inst.mem[8'(a + k)]), 16'(exp_mem[8'(a + k)]));
        for (k = 0; k < rdq.size(); k++)
            chk(16'(rdq[k]), 16'(exp_mem[8'(a + k)]));
        chk(16'(fail), 16'(eb < len));
        chk(16'(viol), 16'h0000);
    end
    endtask

    task t_reset;
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk(16'({cmd_ready, wr_ready, bus_req, ctl_oe, bip_oe, data_oe, done}), 16'h0000);
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(16'({cmd_ready, wr_ready}), 16'h0003);
        repeat (10) @(posedge sys_clk);
        #1;
        chk(16'(viol), 16'h0000);
    end
    endtask
    task t_sizes;
        int s;
    begin
        for (s = 0; s < 4; s++)
        begin
            xfer(1'b1, 2'(s), 8'(16 * (s + 1)), 4'h0, 4'hf);
            xfer(1'b0, 2'(s), 8'(16 * (s + 1)), 4'h0, 4'hf);
        end
    end
    endtask
    task t_waits;
    begin
        xfer(1'b1, BBAT_SZ_2B, 8'h80, 4'h2, 4'hf);
        xfer(1'b0, BBAT_SZ_2B, 8'h80, 4'h3, 4'hf);
        xfer(1'b0, BBAT_SZ_4B, 8'h40, 4'h1, 4'hf);
    end
    endtask
    task t_fifo;
        int n, k;
    begin
        n = 0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge sys_clk);
            wr_valid <= 1'b1;
            wr_data <= pat;
            #1;
            if (wr_ready === 1'b1)
            begin
                tq.push_back(pat);
                pat = pat + 8'h1;
                n++;
            end
        end
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        chk(16'(n), 16'(BBAT_FIFO_DEPTH));
        for (k = 0; k < 4; k++)
            xfer(1'b1, BBAT_SZ_8B, 8'(8'h90 + 8 * k), 4'h1, 4'hf);
        chk(16'(wr_ready), 16'h0001);
        xfer(1'b0, BBAT_SZ_8B, 8'ha8, 4'h0, 4'hf);
    end
    endtask
    task t_error;
    begin
        xfer(1'b0, BBAT_SZ_8B, 8'h90, 4'h0, 4'h2);
        xfer(1'b0, BBAT_SZ_1B, 8'h10, 4'h0, 4'hf);
        xfer(1'b1, BBAT_SZ_8B, 8'h40, 4'h1, 4'h3);
        xfer(1'b0, BBAT_SZ_8B, 8'h40, 4'h0, 4'hf);
    end
    endtask

    initial
    begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        nwait = 4'h0;
        ebeat = 4'hf;
        fails = 0;
        n_compared = 0;
        pat = 8'h01;
        t_reset();
        t_sizes();
        t_waits();
        t_fifo();
        t_error();
        complete_run();
    end
endmodule // tb_byte_bus_arbiter_transfer
